// >>> common/poll_acc_pkg.sv
// Constants and types shared by the field poll accumulator
package poll_acc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_INT_BASE = 10'h000;
  localparam logic [9:0] IDX_FLT_BASE = 10'h040;
  localparam logic [9:0] IDX_FLT_END = 10'h0C0;
  localparam logic [9:0] IDX_PRESET = 10'h304;
  localparam logic [9:0] IDX_HART = 10'h305;
  localparam logic [9:0] IDX_MODE = 10'h306;
  localparam logic [9:0] IDX_PORT = 10'h307;
  localparam logic [9:0] IDX_REV = 10'h308;
  localparam logic [9:0] IDX_STATUS = 10'h309;
  localparam logic [9:0] IDX_DECIMAL = 10'h30A;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h30B;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h30C;
  localparam logic [5:0] IDX_PADDR_HI = 6'h32;
  // Field positions
  localparam int HS_FAIL_LSB = 8;
  localparam int HS_RETRY_LSB = 6;
  localparam int HS_MODEM_BIT = 5;
  localparam int HS_PRIMARY_BIT = 4;
  localparam int MS_SWAP_BIT = 9;
  localparam int MS_BYVAR_BIT = 8;
  localparam int PS_BAUD_LSB = 8;
  localparam int PS_PAR_LSB = 12;
  localparam int IRQ_BAD_BIT = 0;
  localparam int IRQ_GOOD_BIT = 1;
  // Reset values
  localparam logic [15:0] PRESET_RESET = 16'h07CF;
  localparam logic [15:0] HART_RESET = 16'h0070;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] PORT_RESET = 16'h2101;
  // Encodings
  localparam logic [1:0] FAIL_HOLD = 2'h0;
  localparam logic [1:0] FAIL_PRESET = 2'h1;
  localparam logic [1:0] FAIL_NAN = 2'h2;
  localparam logic [31:0] FLOAT_NAN = 32'h7FC00000;
  localparam logic [3:0] BAUD_1200 = 4'h1;
  localparam logic [1:0] PARITY_ODD = 2'h2;
  localparam logic [7:0] MB_ADDR_MAX = 8'hF7;
  localparam logic [2:0] DP_MAX = 3'h5;
  // Poll engine states
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} poll_state_type;
endpackage

// >>> logic/field_poll_register_accumulator.sv
// Field device poll engine, value accumulator and register file
// Contract
// - Failed or missing reply is re-polled up to the retry count (max 3; a count of 0 gives one re-poll).
// - A device declared bad gets the failure value in its registers.
// - Integer copies are signed 16-bit, saturating at -32768 and 32767.
// - Per-variable decimal places 0..5 scale the integer, readable setting.
// - Float copies hold the unscaled value.
// - Answer only at the slave address, which accepts 1 to 247.
// - Port matches the master; plain modem mode runs 1200 baud odd.
// - Layout selectable: grouped per device or per variable type.
// - Float takes two registers, high word first (AB-CD).
// - Option swaps float words to CD-AB.
// - Failure policy: hold last, load preset, or load NaN.
// - At most 16 devices with four variables each.
// - Loop side runs 1200 baud odd regardless of the port setting.
// - Loop timing follows the primary or secondary master role.
`timescale 1ns/100ps
module field_poll_register_accumulator #(
  parameter logic [7:0] HW_REV = 8'h01, // Arbitrary value
  parameter logic [7:0] SW_REV = 8'h01 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  // Loop transaction unit
  output logic poll_req,
  output logic [5:0] poll_addr,
  output logic master_primary,
  output logic [3:0] loop_baud,
  output logic [1:0] loop_parity,
  input wire logic rsp_valid,
  input wire logic rsp_ok,
  input wire logic [127:0] rsp_fixed,
  input wire logic [127:0] rsp_float,
  // Serial port framer
  input wire logic [7:0] frame_addr,
  output logic addr_match,
  output logic [7:0] slave_addr,
  output logic [3:0] port_baud,
  output logic [1:0] port_parity
);
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [15:0] preset;
    logic [15:0] hs;
    logic [15:0] ms;
    logic [15:0] ps;
    logic [3:0][2:0] dp;
    logic [15:0][5:0] paddr;
    logic [63:0][15:0] ivals;
    logic [63:0][31:0] fvals;
    logic [15:0] bad;
    logic [1:0] ist;
    logic [1:0] imask;
    logic irq;
    poll_acc_pkg::poll_state_type st;
    logic [3:0] dev;
    logic [1:0] retry;
    logic req;
    logic [5:0] raddr;
    logic [3:0] baud;
    logic [1:0] par;
    logic match;
    logic primary;
    logic [3:0] lbaud;
    logic [1:0] lpar;
  } state_type;

  state_type state_reg;
  state_type state_next;
  logic [1:0] lim;
  logic fin;

  // Canonical slot {dev,var} from a holding index under the chosen layout
  function automatic logic [5:0] slot(input logic [5:0] h, input logic byvar);
    return byvar ? {h[3:0], h[5:4]} : h;
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] wr16(input logic [15:0] o, input logic [15:0] d,
      input logic [1:0] s);
    return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction

  // Fixed 16.16 value scaled by ten to the decimal places, saturated
  function automatic logic [15:0] scale(input logic [31:0] q, input logic [2:0] d);
    logic [16:0] ten;
    logic signed [49:0] p;
    logic signed [33:0] r;
    case ((d > poll_acc_pkg::DP_MAX) ? poll_acc_pkg::DP_MAX : d)
      3'h0: ten = 17'h00001;
      3'h1: ten = 17'h0000A;
      3'h2: ten = 17'h00064;
      3'h3: ten = 17'h003E8;
      3'h4: ten = 17'h02710;
      default: ten = 17'h186A0;
    endcase
    p = $signed(q) * $signed({1'b0, ten});
    r = 34'(p >>> 16);
    if (r > 34'sh07FFF) return 16'h7FFF;
    if (r < -34'sh08000) return 16'h8000;
    return r[15:0];
  endfunction

  // Signed 16-bit integer to single precision float
  function automatic logic [31:0] i2f(input logic [15:0] v);
    logic [15:0] m;
    logic [4:0] e;
    e = 5'h00;
    m = v[15] ? 16'(-v) : v;
    for (int i = 0; i < 16; i++) if (m[i]) e = 5'(i);
    if (m == 16'h0000) return 32'h00000000;
    m = 16'(m << (5'h0F - e));
    return {v[15], 8'(8'h7F + {3'h0, e}), m[14:0], 8'h00};
  endfunction

  assign lim = (state_reg.hs[7:6] == 2'h0) ? 2'h1 : state_reg.hs[7:6];
  assign fin = state_reg.st == poll_acc_pkg::ST_WAIT && rsp_valid
      && (rsp_ok || state_reg.retry >= lim);

  // Next state: bus access, then poll engine, then interrupt
  always_comb begin
    logic [9:0] a;
    logic [6:0] k;
    logic [31:0] f;
    logic [15:0] t;
    logic [5:0] sl;
    logic [1:0] ev;
    logic take;
    logic wr;
    a = wb_adr_i[11:2];
    k = 7'(a - poll_acc_pkg::IDX_FLT_BASE);
    f = 32'h00000000;
    t = 16'h0000;
    sl = 6'h00;
    ev = 2'h0;
    take = wb_cyc_i && wb_stb_i && !state_reg.ack;
    wr = wb_cyc_i && wb_stb_i && wb_we_i && state_reg.ack;
    state_next = state_reg;
    state_next.ack = take;
    state_next.req = 1'b0;
    // Read mux; unmapped words read zero and are still acked
    state_next.rdat = 32'h00000000;
    if (a < poll_acc_pkg::IDX_FLT_BASE) begin
      state_next.rdat = {16'h0000,
          state_reg.ivals[slot(a[5:0], state_reg.ms[poll_acc_pkg::MS_BYVAR_BIT])]};
    end else if (a < poll_acc_pkg::IDX_FLT_END) begin
      f = state_reg.fvals[slot(k[6:1], state_reg.ms[poll_acc_pkg::MS_BYVAR_BIT])];
      if (k[0] ^ state_reg.ms[poll_acc_pkg::MS_SWAP_BIT]) begin
        state_next.rdat = {16'h0000, f[15:0]};
      end else begin
        state_next.rdat = {16'h0000, f[31:16]};
      end
    end else if (a[9:4] == poll_acc_pkg::IDX_PADDR_HI) begin
      state_next.rdat = {26'h0000000, state_reg.paddr[a[3:0]]};
    end else begin
      case (a)
        poll_acc_pkg::IDX_PRESET: state_next.rdat = {16'h0000, state_reg.preset};
        poll_acc_pkg::IDX_HART: state_next.rdat = {16'h0000, state_reg.hs};
        poll_acc_pkg::IDX_MODE: state_next.rdat = {16'h0000, state_reg.ms};
        poll_acc_pkg::IDX_PORT: state_next.rdat = {16'h0000, state_reg.ps};
        poll_acc_pkg::IDX_REV: state_next.rdat = {16'h0000, HW_REV, SW_REV};
        poll_acc_pkg::IDX_STATUS: state_next.rdat = {16'h0000, state_reg.bad};
        poll_acc_pkg::IDX_DECIMAL: state_next.rdat = {20'h00000, state_reg.dp};
        poll_acc_pkg::IDX_IRQ_STAT: state_next.rdat = {30'h00000000, state_reg.ist};
        poll_acc_pkg::IDX_IRQ_MASK: state_next.rdat = {30'h00000000, state_reg.imask};
        default: state_next.rdat = 32'h00000000;
      endcase
    end
    // Register writes land at the edge where the master samples ack high
    if (wr) begin
      if (a[9:4] == poll_acc_pkg::IDX_PADDR_HI && wb_sel_i[0]) begin
        state_next.paddr[a[3:0]] = wb_dat_i[5:0];
      end
      case (a)
        poll_acc_pkg::IDX_PRESET:
          state_next.preset = wr16(state_reg.preset, wb_dat_i[15:0], wb_sel_i[1:0]);
        poll_acc_pkg::IDX_HART:
          state_next.hs = wr16(state_reg.hs, wb_dat_i[15:0], wb_sel_i[1:0]);
        poll_acc_pkg::IDX_MODE:
          state_next.ms = wr16(state_reg.ms, wb_dat_i[15:0], wb_sel_i[1:0]);
        poll_acc_pkg::IDX_PORT: begin
          t = wr16(state_reg.ps, wb_dat_i[15:0], wb_sel_i[1:0]);
          if (t[7:0] == 8'h00 || t[7:0] > poll_acc_pkg::MB_ADDR_MAX) begin
            t[7:0] = state_reg.ps[7:0];
          end
          state_next.ps = t;
        end
        poll_acc_pkg::IDX_DECIMAL: begin
          t = wr16({4'h0, state_reg.dp}, wb_dat_i[15:0], wb_sel_i[1:0]);
          state_next.dp = t[11:0];
        end
        poll_acc_pkg::IDX_IRQ_STAT:
          if (wb_sel_i[0]) state_next.ist = state_reg.ist & ~wb_dat_i[1:0];
        poll_acc_pkg::IDX_IRQ_MASK:
          if (wb_sel_i[0]) state_next.imask = wb_dat_i[1:0];
        default: ;
      endcase
    end
    // Poll engine
    case (state_reg.st)
      poll_acc_pkg::ST_IDLE: begin
        if (!state_reg.hs[poll_acc_pkg::HS_MODEM_BIT]) begin
          state_next.st = poll_acc_pkg::ST_REQ;
        end
      end
      poll_acc_pkg::ST_REQ: begin
        state_next.req = 1'b1;
        state_next.raddr = state_reg.paddr[state_reg.dev];
        state_next.st = poll_acc_pkg::ST_WAIT;
      end
      poll_acc_pkg::ST_WAIT: begin
        if (rsp_valid && rsp_ok) begin
          for (int v = 0; v < 4; v++) begin
            sl = {state_reg.dev, 2'(v)};
            state_next.ivals[sl] = scale(rsp_fixed[32*v +: 32], state_reg.dp[v]);
            state_next.fvals[sl] = rsp_float[32*v +: 32];
          end
          state_next.bad[state_reg.dev] = 1'b0;
          ev[poll_acc_pkg::IRQ_GOOD_BIT] = 1'b1;
        end else if (rsp_valid && state_reg.retry < lim) begin
          state_next.retry = state_reg.retry + 2'h1;
          state_next.st = poll_acc_pkg::ST_REQ;
        end else if (rsp_valid) begin
          state_next.bad[state_reg.dev] = 1'b1;
          ev[poll_acc_pkg::IRQ_BAD_BIT] = 1'b1;
          for (int v = 0; v < 4; v++) begin
            sl = {state_reg.dev, 2'(v)};
            case (state_reg.hs[9:8])
              poll_acc_pkg::FAIL_PRESET: begin
                state_next.ivals[sl] = state_reg.preset;
                state_next.fvals[sl] = i2f(state_reg.preset);
              end
              poll_acc_pkg::FAIL_NAN: begin
                state_next.ivals[sl] = 16'h0000;
                state_next.fvals[sl] = poll_acc_pkg::FLOAT_NAN;
              end
              default: ;
            endcase
          end
        end
        if (fin) begin
          state_next.retry = 2'h0;
          state_next.dev = (state_reg.dev >= state_reg.hs[3:0]) ? 4'h0
              : state_reg.dev + 4'h1;
          state_next.st = state_reg.hs[poll_acc_pkg::HS_MODEM_BIT]
              ? poll_acc_pkg::ST_IDLE : poll_acc_pkg::ST_REQ;
        end
      end
      default: state_next.st = poll_acc_pkg::ST_IDLE;
    endcase
    // Sticky events; a set wins over a clear in the same cycle
    state_next.ist = state_next.ist | ev;
    state_next.irq = |(state_next.ist & state_next.imask);
    // Port and loop settings
    state_next.match = frame_addr == state_reg.ps[7:0];
    state_next.primary = state_reg.hs[poll_acc_pkg::HS_PRIMARY_BIT];
    state_next.lbaud = poll_acc_pkg::BAUD_1200;
    state_next.lpar = poll_acc_pkg::PARITY_ODD;
    if (state_reg.hs[poll_acc_pkg::HS_MODEM_BIT]) begin
      state_next.baud = poll_acc_pkg::BAUD_1200;
      state_next.par = poll_acc_pkg::PARITY_ODD;
    end else begin
      state_next.baud = state_reg.ps[11:8];
      state_next.par = state_reg.ps[13:12];
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.preset <= poll_acc_pkg::PRESET_RESET;
      state_reg.hs <= poll_acc_pkg::HART_RESET;
      state_reg.ms <= poll_acc_pkg::MODE_RESET;
      state_reg.ps <= poll_acc_pkg::PORT_RESET;
      state_reg.st <= poll_acc_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.rdat;
  assign irq = state_reg.irq;
  assign poll_req = state_reg.req;
  assign poll_addr = state_reg.raddr;
  assign master_primary = state_reg.primary;
  assign loop_baud = state_reg.lbaud;
  assign loop_parity = state_reg.lpar;
  assign addr_match = state_reg.match;
  assign slave_addr = state_reg.ps[7:0];
  assign port_baud = state_reg.baud;
  assign port_parity = state_reg.par;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_retry;
    state_reg.st == poll_acc_pkg::ST_WAIT && rsp_valid && !rsp_ok
        && state_reg.retry < lim |=> state_reg.st == poll_acc_pkg::ST_REQ ##1 poll_req;
  endproperty
  a_retry: assert property (p_retry) else $error("retry not issued");
  property p_declare;
    fin && !rsp_ok |=> state_reg.bad[$past(state_reg.dev)] && state_reg.retry == 2'h0;
  endproperty
  a_declare: assert property (p_declare) else $error("bad flag missing");
  property p_preset;
    fin && !rsp_ok && state_reg.hs[9:8] == poll_acc_pkg::FAIL_PRESET
        |=> state_reg.ivals[{$past(state_reg.dev), 2'h3}] == $past(state_reg.preset);
  endproperty
  a_preset: assert property (p_preset) else $error("preset not loaded");
  property p_nan;
    fin && !rsp_ok && state_reg.hs[9:8] == poll_acc_pkg::FAIL_NAN
        |=> state_reg.ivals[{$past(state_reg.dev), 2'h0}] == 16'h0000
        && state_reg.fvals[{$past(state_reg.dev), 2'h0}] == poll_acc_pkg::FLOAT_NAN;
  endproperty
  a_nan: assert property (p_nan) else $error("NaN policy wrong");
  property p_sat;
    fin && rsp_ok && rsp_fixed[63:32] == 32'h03E80000 && state_reg.dp[1] >= 3'h2
        |=> state_reg.ivals[{$past(state_reg.dev), 2'h1}] == 16'h7FFF;
  endproperty
  a_sat: assert property (p_sat) else $error("no saturation");
  property p_scale;
    fin && rsp_ok && rsp_fixed[31:0] == 32'h00038000 && state_reg.dp[0] == 3'h2
        |=> state_reg.ivals[{$past(state_reg.dev), 2'h0}] == 16'h015E;
  endproperty
  a_scale: assert property (p_scale) else $error("scaling wrong");
  property p_float;
    fin && rsp_ok |=> state_reg.fvals[{$past(state_reg.dev), 2'h2}] == $past(rsp_float[95:64]);
  endproperty
  a_float: assert property (p_float) else $error("float not stored");
  property p_word;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i[11:2] == 10'h040
        && state_reg.ms[9:8] == 2'h0 |=> wb_ack_o && wb_dat_o[15:0] == $past(state_reg.fvals[0][31:16]);
  endproperty
  a_word: assert property (p_word) else $error("float word order");
  property p_swap;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i[11:2] == 10'h040
        && state_reg.ms[9:8] == 2'h2 |=> wb_dat_o[15:0] == $past(state_reg.fvals[0][15:0]);
  endproperty
  a_swap: assert property (p_swap) else $error("swap order");
  property p_map;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i[11:2] == 10'h001
        && state_reg.ms[8] |=> wb_dat_o[15:0] == $past(state_reg.ivals[4]);
  endproperty
  a_map: assert property (p_map) else $error("variable layout");
  property p_addr;
    wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i[11:2] == 10'h307
        && wb_sel_i[0] && wb_dat_i[7:0] == 8'h00 |=> slave_addr == $past(slave_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("address 0 accepted");
  property p_wrap;
    fin && state_reg.dev >= state_reg.hs[3:0] |=> state_reg.dev == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("poll did not wrap");
  property p_req;
    poll_req |-> poll_addr == state_reg.paddr[state_reg.dev] && state_reg.st == poll_acc_pkg::ST_WAIT;
  endproperty
  a_req: assert property (p_req) else $error("wrong poll address");
  property p_modem;
    state_reg.hs[5] |=> port_baud == 4'h1 && port_parity == 2'h2;
  endproperty
  a_modem: assert property (p_modem) else $error("modem port setting");
  c_bad: cover property (fin && !rsp_ok);
  c_good: cover property (fin && rsp_ok ##[1:20] poll_req);
  c_irq: cover property ($rose(irq));
endmodule

// >>> sim/loop_unit_model.sv
// Behavioural loop transaction unit that answers the block's polls
`timescale 1ns/100ps
module loop_unit_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Poll requests from the block
  input wire logic poll_req,
  input wire logic [5:0] poll_addr,
  // Bench controls: failing address and answer delay
  input wire logic [5:0] bad_addr,
  input wire logic bad_en,
  input wire logic [3:0] delay,
  // Answers to the block
  output logic rsp_valid,
  output logic rsp_ok,
  output logic [127:0] rsp_fixed,
  output logic [127:0] rsp_float
);
  logic [3:0] cnt;
  logic [5:0] addr;

  // One answer per poll after the delay; data lines toggle while idle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      addr <= 6'h00;
      rsp_valid <= 1'b0;
      rsp_ok <= 1'b0;
      rsp_fixed <= '0;
      rsp_float <= '0;
    end else begin
      rsp_valid <= 1'b0;
      rsp_ok <= ~rsp_ok;
      rsp_fixed <= ~rsp_fixed;
      rsp_float <= ~rsp_float;
      if (poll_req) begin
        cnt <= delay;
        addr <= poll_addr;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
      if (cnt == 4'h1) begin
        rsp_valid <= 1'b1;
        rsp_ok <= !(bad_en && addr == bad_addr); // No reply reported as a failure
        rsp_fixed <= {32'h00004000, 32'hFC180000, 32'h03E80000, 32'h00038000};
        for (int v = 0; v < 4; v++) begin
          rsp_float[32*v+:32] <= 32'h41200000 | (v << 16) | addr;
        end
      end
    end
  end
endmodule

// >>> sim/field_poll_register_accumulator_tb_top.sv
// Self-checking bench for the field poll accumulator
`timescale 1ns/100ps
module field_poll_register_accumulator_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] bus_data, rd_data;
  logic ack, irq, poll_req, master_primary, rsp_valid, rsp_ok, addr_match;
  logic [5:0] poll_addr;
  logic [5:0] bad_addr = 6'h00;
  logic bad_en = 1'b0;
  logic [3:0] delay = 4'h1;
  logic [3:0] loop_baud, port_baud;
  logic [1:0] loop_parity, port_parity;
  logic [7:0] frame_addr = 8'h00;
  logic [7:0] slave_addr;
  logic [127:0] rsp_fixed, rsp_float;
  logic [5:0] pq[$];
  int fail_count = 0;
  int samples_checked = 0;

  // Clock at 100 MHz
  always #5 clk = ~clk;

  field_poll_register_accumulator dut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(bus_data),
    .wb_ack_o(ack), .irq(irq), .poll_req(poll_req), .poll_addr(poll_addr),
    .master_primary(master_primary), .loop_baud(loop_baud),
    .loop_parity(loop_parity), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
    .rsp_fixed(rsp_fixed), .rsp_float(rsp_float), .frame_addr(frame_addr),
    .addr_match(addr_match), .slave_addr(slave_addr), .port_baud(port_baud),
    .port_parity(port_parity)
  );

  loop_unit_model partner (
    .clk(clk), .rst_n(rst_n), .poll_req(poll_req), .poll_addr(poll_addr),
    .bad_addr(bad_addr), .bad_en(bad_en), .delay(delay), .rsp_valid(rsp_valid),
    .rsp_ok(rsp_ok), .rsp_fixed(rsp_fixed), .rsp_float(rsp_float)
  );

  // Record poll addresses away from the active edge
  always @(negedge clk) begin
    if (poll_req === 1'b1) begin
      pq.push_back(poll_addr);
    end
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic Wishbone single cycle
  task automatic wb(input logic w, input logic [9:0] idx, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h3;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    rd_data = bus_data;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (k >= 50) check(32'h0, 32'h1);
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [15:0] exp);
    wb(1'b0, idx, 16'h0000);
    check(rd_data, {16'h0000, exp});
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Collect a number of polls under a bound
  task automatic wait_polls(input int n);
    int k;
    k = 0;
    pq.delete();
    while (pq.size() < n && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) check(32'h0, 32'h1);
  endtask

  task automatic t_reset();
    settle();
    check(slave_addr, 8'h01);
    check(loop_baud, poll_acc_pkg::BAUD_1200);
    check(loop_parity, poll_acc_pkg::PARITY_ODD);
    check(master_primary, 1'b1);
    rd_chk(poll_acc_pkg::IDX_PRESET, poll_acc_pkg::PRESET_RESET);
    rd_chk(poll_acc_pkg::IDX_HART, poll_acc_pkg::HART_RESET);
    rd_chk(poll_acc_pkg::IDX_MODE, poll_acc_pkg::MODE_RESET);
    rd_chk(poll_acc_pkg::IDX_PORT, poll_acc_pkg::PORT_RESET);
    rd_chk(10'h3FF, 16'h0000);
    $display("reset test done");
  endtask

  task automatic t_port();
    wb(1'b1, poll_acc_pkg::IDX_PORT, 16'h14F7);
    settle();
    check(slave_addr, 8'hF7);
    check(port_baud, poll_acc_pkg::BAUD_1200);
    check(port_parity, poll_acc_pkg::PARITY_ODD);
    wb(1'b1, poll_acc_pkg::IDX_PORT, 16'h1400);
    wb(1'b1, poll_acc_pkg::IDX_PORT, 16'h14F8);
    rd_chk(poll_acc_pkg::IDX_PORT, 16'h14F7);
    @(posedge clk);
    frame_addr <= 8'hF7;
    settle();
    check(addr_match, 1'b1);
    @(posedge clk);
    frame_addr <= 8'h01;
    settle();
    check(addr_match, 1'b0);
    $display("port test done");
  endtask

  task automatic t_good();
    wb(1'b1, {poll_acc_pkg::IDX_PADDR_HI, 4'h0}, 16'h0005);
    wb(1'b1, {poll_acc_pkg::IDX_PADDR_HI, 4'h1}, 16'h0006);
    wb(1'b1, poll_acc_pkg::IDX_DECIMAL, 16'h0A92);
    wb(1'b1, poll_acc_pkg::IDX_HART, 16'h0091);
    wait_polls(6);
    for (int i = 0; i < 5; i++) check(pq[i + 1], pq[i] === 6'h05 ? 6'h06 : 6'h05);
    check(port_baud, 4'h4);
    check(port_parity, 2'h1);
    rd_chk(10'h000, 16'h015E);
    rd_chk(10'h001, 16'h7FFF);
    rd_chk(10'h002, 16'h8000);
    rd_chk(10'h003, 16'h61A8);
    rd_chk(poll_acc_pkg::IDX_DECIMAL, 16'h0A92);
    rd_chk(10'h040, 16'h4120);
    rd_chk(10'h041, 16'h0005);
    rd_chk(10'h04A, 16'h4121);
    rd_chk(poll_acc_pkg::IDX_STATUS, 16'h0000);
    wb(1'b1, poll_acc_pkg::IDX_MODE, 16'h0200);
    rd_chk(10'h040, 16'h0005);
    rd_chk(10'h041, 16'h4120);
    wb(1'b1, poll_acc_pkg::IDX_MODE, 16'h0100);
    rd_chk(10'h031, 16'h61A8);
    rd_chk(10'h001, 16'h015E);
    wb(1'b1, poll_acc_pkg::IDX_MODE, 16'h0000);
    $display("good poll test done");
  endtask

  // Second device stops answering under each failure policy
  task automatic t_fail();
    logic [15:0] ei[3] = '{16'h015E, 16'h07CF, 16'h0000};
    logic [15:0] ef[3] = '{16'h4120, 16'h44F9, 16'h7FC0};
    int j;
    bad_addr <= 6'h06;
    bad_en <= 1'b1;
    delay <= 4'h7;
    for (int m = 0; m < 3; m++) begin
      wb(1'b1, poll_acc_pkg::IDX_HART, 16'(m << 8) | 16'h0091);
      wait_polls(10);
      j = 0;
      while (j < 5 && !(pq[j] === 6'h05 && pq[j + 1] === 6'h06)) j++;
      check({pq[j + 1], pq[j + 2], pq[j + 3], pq[j + 4]}, 24'h186185);
      rd_chk(10'h004, ei[m]);
      rd_chk(10'h048, ef[m]);
      rd_chk(poll_acc_pkg::IDX_STATUS, 16'h0002);
    end
    $display("failure test done");
  endtask

  task automatic t_irq();
    wb(1'b1, poll_acc_pkg::IDX_IRQ_MASK, 16'h0001);
    wait_polls(5);
    check(irq, 1'b1);
    wb(1'b0, poll_acc_pkg::IDX_IRQ_STAT, 16'h0000);
    check(rd_data[1:0], 2'h3);
    wb(1'b1, poll_acc_pkg::IDX_IRQ_MASK, 16'h0000);
    settle();
    check(irq, 1'b0);
    wb(1'b1, poll_acc_pkg::IDX_HART, 16'h0020);
    repeat (30) @(posedge clk);
    check(master_primary, 1'b0);
    wb(1'b1, poll_acc_pkg::IDX_IRQ_STAT, 16'h0003);
    rd_chk(poll_acc_pkg::IDX_IRQ_STAT, 16'h0000);
    wb(1'b1, poll_acc_pkg::IDX_IRQ_MASK, 16'h0003);
    settle();
    check(irq, 1'b0);
    $display("interrupt test done");
  endtask

  // Print the counts and the verdict, then stop
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_port();
    t_good();
    t_fail();
    t_irq();
    summarize();
  end

  // Watchdog against a hang
  initial begin
    #300000;
    fail_count++;
    summarize();
  end
endmodule
